//--- core/ipn_lvl_if.sv
// Purpose: Carries level-store access between the gate unit and its store.
// Assumes: Single clock, same domain on both sides.
// Notes: The store also returns all register read data from its own flop.
`timescale 1ns/1ps
interface ipn_lvl_if;
    import ipn_pkg::*;
    logic wr;
    logic [LVL_IDX_W-1:0] idx;
    logic [DATA_W-1:0] wdata;
    logic rd;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] sc_byte;
    logic [DATA_W-1:0] stack_byte;
    logic [DATA_W-1:0] rdata;
    ipn_levels_t levels;
    modport ctrl (output wr, idx, wdata, rd, rd_addr, sc_byte, stack_byte,
                  input rdata, levels);
    modport store (input wr, idx, wdata, rd, rd_addr, sc_byte, stack_byte,
                   output rdata, levels);
endinterface

//--- core/ipn_lvl_store.sv
// Purpose: Holds the per-source level bytes and registers all read data.
// Assumes: Writes and reads come from the gate unit on the same clock.
// Notes: Level bytes stay readable and writable whatever the gate state.
`timescale 1ns/1ps
module ipn_lvl_store
    import ipn_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    ipn_lvl_if.store bus
);
    logic [DATA_W-1:0] mem_r [LVL_REGS];
    logic [DATA_W-1:0] mem_nxt [LVL_REGS];
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rdata_nxt;
    logic [5:0] rel;

    always_comb begin
        rel = bus.rd_addr - OFS_LVL0;
        for (int i = 0; i < LVL_REGS; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (bus.wr) begin
            mem_nxt[bus.idx] = bus.wdata;
        end
        rdata_nxt = 8'h00;
        if (bus.rd && bus.rd_addr == OFS_SC) begin
            rdata_nxt = bus.sc_byte;
        end else if (bus.rd && bus.rd_addr == OFS_STACK) begin
            rdata_nxt = bus.stack_byte;
        end else if (bus.rd && bus.rd_addr >= OFS_LVL0 && bus.rd_addr <= OFS_LVL_LAST) begin
            rdata_nxt = mem_r[rel[LVL_IDX_W-1:0]];
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            for (int i = 0; i < LVL_REGS; i++) begin
                mem_r[i] <= LVL_RST;
            end
            rdata_r <= 8'h00;
        end else begin
            mem_r <= mem_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    always_comb begin
        for (int i = 0; i < LVL_REGS; i++) begin
            bus.levels[i*DATA_W +: DATA_W] = mem_r[i];
        end
    end
    assign bus.rdata = rdata_r;
endmodule

//--- core/ipn_pkg.sv
// Purpose: Shared constants for the interrupt priority gate unit.
// Assumes: Byte-wide register port, 48 request sources, one 250 MHz clock.
// Notes: Register offsets are byte offsets on the plain register port.
package ipn_pkg;
    localparam int SRC_N = 48;
    localparam int LVL_REGS = 12;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int LVL_W = 2;
    localparam int LVL_IDX_W = 4;
    localparam logic [5:0] OFS_SC = 6'h00;
    localparam logic [5:0] OFS_STACK = 6'h01;
    localparam logic [5:0] OFS_LVL0 = 6'h02;
    localparam logic [5:0] OFS_LVL_LAST = 6'h0D;
    localparam int EN_BIT = 7;
    localparam int EMPTY_BIT = 5;
    localparam int FULL_BIT = 4;
    localparam int POP_BIT = 3;
    localparam logic [2:0] STACK_DEPTH = 3'h4;
    localparam logic [1:0] MASK_RST = 2'h0;
    localparam logic [7:0] STACK_RST = 8'h00;
    localparam logic [7:0] LVL_RST = 8'h00;
    localparam logic [1:0] STOP_MASK = 2'h0;
    // Highest vector slot in the low address bits; each vector takes two bytes.
    localparam logic [5:0] VEC_TOP = 6'h3F;
    typedef logic [SRC_N*LVL_W-1:0] ipn_levels_t;

    // Source index from the low address bits seen during a vector fetch.
    function automatic logic [5:0] ipn_src_of_addr(input logic [5:0] addr);
        logic [5:0] diff;
        diff = VEC_TOP - addr;
        return {1'b0, diff[5:1]};
    endfunction

    // Level of one source out of the flat level vector.
    function automatic logic [1:0] ipn_level_of(input ipn_levels_t lv, input logic [5:0] src);
        return lv[src*LVL_W +: LVL_W];
    endfunction
endpackage

//--- core/ipn_priority_gate_unit.sv
// Purpose: Gates core interrupt requests by programmable level and nests the mask.
// Assumes: Requests, fetch strobe and stop mode are synchronous to clk_in.
// Notes: Qualified requests are registered, so they lag the raw lines by one cycle.
//
// Behaviour
// - Each source has a 2-bit level 0..3; 3 is most urgent.
// - Level fields are readable and writable at any time.
// - Enabled: request passes only when its level is at least the mask.
// - In shallow stop the compare uses mask zero, so all requests pass.
// - Disabled: raw requests go straight to the core outputs.
// - Levels only gate; core arbitration order is untouched.
// - The mask sits in bits 1:0 of the status and control register.
// - A vector fetch while enabled loads the mask with the serviced source's level.
// - A fetch-driven mask update pushes the old mask onto the stack.
// - Writing one to the pop command while enabled restores the mask from the stack.
// - The history stack holds exactly four 2-bit entries.
// - Full flag is set when the last entry fills, updated each push/pop.
// - Empty flag is set when every saved entry has been popped.
// - Enable is bit 7; when clear, requests bypass and the stack never changes.
// - Push puts newest in bits 7:6, oldest falls out of bits 1:0.
// - Pop moves bits 7:6 into the mask and shifts zeros into bits 1:0.
// - Direct mask writes do not push; with pop while enabled, pop wins.
`timescale 1ns/1ps
module ipn_priority_gate_unit
    import ipn_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [DATA_W-1:0] reg_rdata_out,
    input wire logic [SRC_N-1:0] raw_irq_in,
    input wire logic vector_fetch_strobe_in,
    input wire logic [5:0] core_addr_low_in,
    input wire logic shallow_stop_mode_in,
    output logic [SRC_N-1:0] qualified_irq_out
);
    ////////////////////////////////////////////////////////////////////////////
    // Level store and register reads.

    ipn_lvl_if lvl ();

    ipn_lvl_store u_store (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .bus(lvl.store)
    );

    logic gate_enable_bit_r;
    logic gate_enable_bit_nxt;
    logic [1:0] priority_mask_r;
    logic [1:0] priority_mask_nxt;
    logic [7:0] mask_history_stack_r;
    logic [7:0] mask_history_stack_nxt;
    logic [2:0] depth_r;
    logic [2:0] depth_nxt;
    logic fetch_d_r;
    logic fetch_d_nxt;
    logic [SRC_N-1:0] qirq_r;
    logic [SRC_N-1:0] qirq_nxt;
    logic sc_wr;
    logic lvl_wr;
    logic [5:0] lvl_rel;
    logic fetch_edge;
    logic mask_pop_cmd;
    logic history_full_flag;
    logic history_empty_flag;
    logic [5:0] fetch_src;
    logic [1:0] fetch_level;
    logic [1:0] eff_mask;

    assign sc_wr = reg_wr_in && reg_addr_in == OFS_SC;
    assign lvl_rel = reg_addr_in - OFS_LVL0;
    assign lvl_wr = reg_wr_in && reg_addr_in >= OFS_LVL0 && reg_addr_in <= OFS_LVL_LAST;
    assign history_full_flag = depth_r == STACK_DEPTH;
    assign history_empty_flag = depth_r == 3'h0;

    // Level bytes are open to software regardless of enable or activity.
    assign lvl.wr = lvl_wr;
    assign lvl.idx = lvl_rel[LVL_IDX_W-1:0];
    assign lvl.wdata = reg_wdata_in;
    assign lvl.rd = reg_rd_in;
    assign lvl.rd_addr = reg_addr_in;
    assign lvl.sc_byte = {gate_enable_bit_r, 1'b0, history_empty_flag,
                          history_full_flag, 2'b00, priority_mask_r};
    assign lvl.stack_byte = mask_history_stack_r;
    assign reg_rdata_out = lvl.rdata;

    ////////////////////////////////////////////////////////////////////////////
    // Mask update, push and pop.

    // Only the rising edge counts, so a strobe held for several cycles pushes once.
    assign fetch_edge = vector_fetch_strobe_in && !fetch_d_r;
    assign fetch_src = ipn_src_of_addr(core_addr_low_in);
    assign fetch_level = ipn_level_of(lvl.levels, fetch_src);
    // Pop acts only while already enabled, matching the bypass that freezes the stack.
    assign mask_pop_cmd = sc_wr && reg_wdata_in[POP_BIT] && gate_enable_bit_r;

    always_comb begin
        gate_enable_bit_nxt = gate_enable_bit_r;
        priority_mask_nxt = priority_mask_r;
        mask_history_stack_nxt = mask_history_stack_r;
        depth_nxt = depth_r;
        fetch_d_nxt = vector_fetch_strobe_in;
        if (sc_wr) begin
            gate_enable_bit_nxt = reg_wdata_in[EN_BIT];
            priority_mask_nxt = reg_wdata_in[1:0];
        end
        if (mask_pop_cmd) begin
            priority_mask_nxt = mask_history_stack_r[7:6];
            mask_history_stack_nxt = {mask_history_stack_r[5:0], 2'b00};
            if (depth_r != 3'h0) begin
                depth_nxt = depth_r - 3'h1;
            end
        end
        // A fetch in the same cycle as a pop stacks the popped value again.
        if (fetch_edge && gate_enable_bit_r) begin
            mask_history_stack_nxt = {priority_mask_nxt, mask_history_stack_nxt[7:2]};
            priority_mask_nxt = fetch_level;
            if (depth_nxt != STACK_DEPTH) begin
                depth_nxt = depth_nxt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            gate_enable_bit_r <= 1'b0;
            priority_mask_r <= MASK_RST;
            mask_history_stack_r <= STACK_RST;
            depth_r <= 3'h0;
            fetch_d_r <= 1'b0;
        end else begin
            gate_enable_bit_r <= gate_enable_bit_nxt;
            priority_mask_r <= priority_mask_nxt;
            mask_history_stack_r <= mask_history_stack_nxt;
            depth_r <= depth_nxt;
            fetch_d_r <= fetch_d_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request qualification.

    // Stop mode substitutes a zero mask rather than changing the stored one.
    assign eff_mask = shallow_stop_mode_in ? STOP_MASK : priority_mask_r;

    always_comb begin
        for (int i = 0; i < SRC_N; i++) begin
            if (!gate_enable_bit_r) begin
                qirq_nxt[i] = raw_irq_in[i];
            end else begin
                // Each line is gated alone; no ordering between sources is imposed.
                qirq_nxt[i] = raw_irq_in[i]
                    && ipn_level_of(lvl.levels, 6'(i)) >= eff_mask;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            qirq_r <= '0;
        end else begin
            qirq_r <= qirq_nxt;
        end
    end
    assign qualified_irq_out = qirq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    bypass_pass_a: assert property (
        !gate_enable_bit_r |=> qualified_irq_out == $past(raw_irq_in))
        else $error("Bypass did not forward raw requests.");

    gate_block_a: assert property (
        gate_enable_bit_r && !shallow_stop_mode_in && raw_irq_in[5]
            && lvl.levels[11:10] < priority_mask_r |=> !qualified_irq_out[5])
        else $error("Request below the mask reached the core.");

    gate_allow_a: assert property (
        gate_enable_bit_r && raw_irq_in[5]
            && lvl.levels[11:10] >= priority_mask_r |=> qualified_irq_out[5])
        else $error("Request at or above the mask was blocked.");

    stop_pass_a: assert property (
        gate_enable_bit_r && shallow_stop_mode_in |=> qualified_irq_out == $past(raw_irq_in))
        else $error("Shallow stop did not pass every request.");

    fetch_load_a: assert property (
        fetch_edge && gate_enable_bit_r |=> priority_mask_r == $past(fetch_level))
        else $error("Fetch did not load the serviced level.");

    push_shift_a: assert property (
        fetch_edge && gate_enable_bit_r && !mask_pop_cmd |=> mask_history_stack_r
            == {$past(priority_mask_r), $past(mask_history_stack_r[7:2])})
        else $error("Fetch did not push the old mask.");

    pop_restore_a: assert property (
        mask_pop_cmd && !fetch_edge |=> priority_mask_r == $past(mask_history_stack_r[7:6])
            && mask_history_stack_r[1:0] == 2'b00)
        else $error("Pop did not restore the stacked mask.");

    stack_frozen_a: assert property (
        !gate_enable_bit_r |=> $stable(mask_history_stack_r) && $stable(depth_r))
        else $error("Stack changed while the gate was disabled.");

    full_set_a: assert property (
        fetch_edge && gate_enable_bit_r && !mask_pop_cmd && depth_r == 3'h3
            |=> history_full_flag ##1 history_full_flag || $past(mask_pop_cmd))
        else $error("Full flag missing after fourth push.");

    empty_set_a: assert property (
        mask_pop_cmd && !fetch_edge && depth_r == 3'h1 |=> history_empty_flag)
        else $error("Empty flag missing after last pop.");

    mask_write_a: assert property (
        sc_wr && !reg_wdata_in[POP_BIT] && !fetch_edge |=> priority_mask_r
            == $past(reg_wdata_in[1:0]) && $stable(mask_history_stack_r))
        else $error("Direct mask write misbehaved.");

    held_once_a: assert property (
        vector_fetch_strobe_in && fetch_d_r && !mask_pop_cmd
            |=> $stable(mask_history_stack_r) && $stable(depth_r))
        else $error("Held fetch strobe pushed more than once.");

    fetch_idle_a: assert property (
        fetch_edge && !gate_enable_bit_r && !sc_wr |=> $stable(priority_mask_r))
        else $error("Fetch changed the mask while the gate was disabled.");

    pop_ignored_a: assert property (
        sc_wr && reg_wdata_in[POP_BIT] && !gate_enable_bit_r
            |=> priority_mask_r == $past(reg_wdata_in[1:0]))
        else $error("Pop acted while the gate was disabled.");

    enable_write_a: assert property (
        sc_wr |=> gate_enable_bit_r == $past(reg_wdata_in[EN_BIT]))
        else $error("Enable bit did not take the written value.");

    depth_cap_a: assert property (
        depth_r <= STACK_DEPTH)
        else $error("History depth exceeded four entries.");

    full_hold_a: assert property (
        history_full_flag && fetch_edge && gate_enable_bit_r && !mask_pop_cmd
            |=> history_full_flag)
        else $error("Push at full cleared the full flag.");

    full_clear_a: assert property (
        history_full_flag && mask_pop_cmd && !fetch_edge |=> !history_full_flag)
        else $error("Full flag stayed set after a pop.");

    empty_clear_a: assert property (
        history_empty_flag && fetch_edge && gate_enable_bit_r |=> !history_empty_flag)
        else $error("Empty flag stayed set after a push.");

    empty_hold_a: assert property (
        history_empty_flag && mask_pop_cmd && !fetch_edge |=> history_empty_flag)
        else $error("Pop of an empty stack cleared the empty flag.");

    pop_shift_a: assert property (
        mask_pop_cmd && !fetch_edge
            |=> mask_history_stack_r == {$past(mask_history_stack_r[5:0]), 2'b00})
        else $error("Pop did not shift the stack with zero fill.");

    stop_keep_a: assert property (
        shallow_stop_mode_in && !sc_wr && !fetch_edge |=> $stable(priority_mask_r))
        else $error("Shallow stop altered the stored mask.");

    // Read data are registered, so reads are judged against the state one cycle earlier.
    level_write_a: assert property (
        lvl_wr && reg_addr_in == OFS_LVL0 |=> lvl.levels[7:0] == $past(reg_wdata_in))
        else $error("Level byte write did not land.");

    level_read_a: assert property (
        reg_rd_in && reg_addr_in == OFS_LVL0 |=> reg_rdata_out == $past(lvl.levels[7:0]))
        else $error("Level byte read returned the wrong value.");

    sc_read_a: assert property (
        reg_rd_in && reg_addr_in == OFS_SC
            |=> reg_rdata_out[1:0] == $past(priority_mask_r)
            && reg_rdata_out[EN_BIT] == $past(gate_enable_bit_r))
        else $error("Status read did not show mask and enable.");

    stack_read_a: assert property (
        reg_rd_in && reg_addr_in == OFS_STACK
            |=> reg_rdata_out == $past(mask_history_stack_r))
        else $error("Stack read returned the wrong value.");

    read_idle_a: assert property (
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("Read data stood outside the read answer cycle.");

    gate_low_a: assert property (
        gate_enable_bit_r && !shallow_stop_mode_in && raw_irq_in[0]
            && lvl.levels[1:0] < priority_mask_r |=> !qualified_irq_out[0])
        else $error("Low level request on line zero reached the core.");
endmodule

//--- verification/ipn_core_model.sv
// Purpose: Core-side model that performs vector fetches when the bench asks.
// Assumes: One clock; strobe and address change only just after rising edges.
// Notes: Outside a fetch the address lines carry a changing pattern, not the last vector.
`timescale 1ns/1ps
module ipn_core_model (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic fetch_go_in,
    input wire logic [4:0] fetch_src_in,
    input wire logic [3:0] fetch_hold_in,
    output logic vector_fetch_strobe_out,
    output logic [5:0] core_addr_low_out,
    output logic busy_out
);
    logic [3:0] hold_r;
    logic gap_r;

    // The gap cycle keeps the strobe low between two fetches.
    assign busy_out = vector_fetch_strobe_out | gap_r;

    // Strobe and address come straight from flops, so they are synchronous.
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            hold_r <= 4'h0;
            gap_r <= 1'b0;
            vector_fetch_strobe_out <= 1'b0;
            core_addr_low_out <= 6'h00;
        end else if (fetch_go_in && !busy_out) begin
            hold_r <= fetch_hold_in - 4'h1;
            vector_fetch_strobe_out <= 1'b1;
            core_addr_low_out <= 6'h3F - {fetch_src_in, 1'b0};
        end else if (hold_r != 4'h0) begin
            hold_r <= hold_r - 4'h1;
        end else if (vector_fetch_strobe_out) begin
            vector_fetch_strobe_out <= 1'b0;
            gap_r <= 1'b1;
            core_addr_low_out <= ~core_addr_low_out;
        end else begin
            gap_r <= 1'b0;
            core_addr_low_out <= core_addr_low_out + 6'h15;
        end
    end
endmodule

//--- verification/ipn_priority_gate_unit_tb_top.sv
// Purpose: Self-checking bench for the interrupt priority gate unit.
// Assumes: Register port answers reads one cycle later; qualified lines lag by one cycle.
// Notes: Levels: src0=1 src1=2 src2=3 src4=3 src5=2 src6=1 src44=2 src45=1 src47=3, rest 0.
`timescale 1ns/1ps
module ipn_priority_gate_unit_tb_top;
    import ipn_pkg::*;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic [SRC_N-1:0] raw_irq = '0;
    logic stop_mode = 1'b0;
    logic [SRC_N-1:0] qual_irq;
    logic fetch_go = 1'b0;
    logic [4:0] fetch_src = '0;
    logic [3:0] fetch_hold = 4'h1;
    logic strobe;
    logic [5:0] core_addr;
    logic busy;
    int miscompares = 0;
    int cmp_count = 0;
    int cycles = 0;

    ipn_priority_gate_unit uut (.clk_in(clk_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .raw_irq_in(raw_irq), .vector_fetch_strobe_in(strobe),
        .core_addr_low_in(core_addr), .shallow_stop_mode_in(stop_mode),
        .qualified_irq_out(qual_irq));
    ipn_core_model core_model (.clk_in(clk_in), .rst_in(rst_in), .fetch_go_in(fetch_go),
        .fetch_src_in(fetch_src), .fetch_hold_in(fetch_hold),
        .vector_fetch_strobe_out(strobe), .core_addr_low_out(core_addr), .busy_out(busy));

    initial begin
        forever #2 clk_in = ~clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic summarize();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [47:0] seen, input logic [47:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_in);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_in);
        reg_wr <= 1'b0;
    endtask

    task automatic reg_check(input string what, input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk_in);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_in);
        reg_rd <= 1'b0;
        #1;
        check(what, {40'h0, reg_rdata}, {40'h0, exp});
    endtask

    task automatic do_fetch(input logic [4:0] src, input logic [3:0] hold);
        int n;
        n = 0;
        @(posedge clk_in);
        fetch_go <= 1'b1;
        fetch_src <= src;
        fetch_hold <= hold;
        @(posedge clk_in);
        fetch_go <= 1'b0;
        #1;
        while (busy !== 1'b0 && n < 40) begin
            @(posedge clk_in);
            #1;
            n++;
        end
        check("fetch done", {47'h0, busy}, 48'h0);
    endtask

    task automatic irq_check(input logic [47:0] raw, input logic stop, input logic [47:0] exp);
        @(posedge clk_in);
        raw_irq <= raw;
        stop_mode <= stop;
        repeat (3) @(posedge clk_in);
        #1;
        check("qualified", qual_irq, exp);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        reg_check("sc reset", OFS_SC, 8'h20);
        reg_check("stack reset", OFS_STACK, 8'h00);
        reg_check("level reset", OFS_LVL_LAST, 8'h00);
        reg_check("unmapped", 6'h3F, 8'h00);
    endtask

    task automatic t_levels();
        reg_write(OFS_LVL0, 8'h39);
        reg_write(OFS_LVL0 + 6'h01, 8'h1B);
        reg_write(OFS_LVL_LAST, 8'hC6);
        reg_check("level 0", OFS_LVL0, 8'h39);
        reg_check("level 1", OFS_LVL0 + 6'h01, 8'h1B);
        reg_check("level 11", OFS_LVL_LAST, 8'hC6);
    endtask

    task automatic t_bypass();
        irq_check(48'hA5C3_0000_F00F, 1'b0, 48'hA5C3_0000_F00F);
        do_fetch(5'd2, 4'h1);
        reg_check("stack frozen", OFS_STACK, 8'h00);
        reg_check("sc frozen", OFS_SC, 8'h20);
        reg_write(OFS_SC, 8'h09);
        reg_check("pop ignored", OFS_SC, 8'h21);
        reg_check("stack kept", OFS_STACK, 8'h00);
    endtask

    task automatic t_gating();
        reg_write(OFS_SC, 8'h82);
        irq_check(48'h2F, 1'b0, 48'h26);
        reg_check("mask write", OFS_SC, 8'hA2);
        reg_check("no push", OFS_STACK, 8'h00);
        irq_check(48'h2F, 1'b1, 48'h2F);
        irq_check(48'h2F, 1'b0, 48'h26);
        reg_check("level live", OFS_LVL0 + 6'h01, 8'h1B);
        reg_write(OFS_SC, 8'h83);
        irq_check(48'h2F, 1'b0, 48'h04);
        irq_check(48'h0, 1'b0, 48'h0);
    endtask

    task automatic t_nesting();
        logic [4:0] srcs [5] = '{5'd0, 5'd1, 5'd2, 5'd4, 5'd5};
        logic [3:0] holds [5] = '{4'h1, 4'h1, 4'h6, 4'h1, 4'h1};
        logic [7:0] f_sc [5] = '{8'h81, 8'h82, 8'h83, 8'h93, 8'h92};
        logic [7:0] f_stk [5] = '{8'h00, 8'h40, 8'h90, 8'hE4, 8'hF9};
        logic [7:0] p_wr [5] = '{8'h88, 8'h88, 8'h88, 8'h8A, 8'h88};
        logic [7:0] p_sc [5] = '{8'h83, 8'h83, 8'h82, 8'hA1, 8'hA0};
        logic [7:0] p_stk [5] = '{8'hE4, 8'h90, 8'h40, 8'h00, 8'h00};
        reg_write(OFS_SC, 8'h80);
        for (int i = 0; i < 5; i++) begin
            do_fetch(srcs[i], holds[i]);
            reg_check("fetch sc", OFS_SC, f_sc[i]);
            reg_check("fetch stack", OFS_STACK, f_stk[i]);
        end
        // The fourth pop also writes mask 2, which the popped value must override.
        // The fifth pops an empty stack, which must stay empty.
        for (int i = 0; i < 5; i++) begin
            reg_write(OFS_SC, p_wr[i]);
            reg_check("pop sc", OFS_SC, p_sc[i]);
            reg_check("pop stack", OFS_STACK, p_stk[i]);
        end
    endtask

    task automatic t_preempt();
        do_fetch(5'd1, 4'h1);
        reg_check("preempt sc", OFS_SC, 8'h82);
        irq_check(48'h23, 1'b0, 48'h22);
        // The service routine drops its own request; the equal level would still pass.
        irq_check(48'h20, 1'b0, 48'h20);
        reg_write(OFS_SC, 8'h88);
        reg_check("preempt pop", OFS_SC, 8'hA0);
        irq_check(48'h21, 1'b0, 48'h21);
        irq_check(48'h0, 1'b0, 48'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Ceiling sits far above the roughly 175 cycles the sequence needs.
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            summarize();
        end
    end

    initial begin
        repeat (2) @(posedge clk_in);
        rst_in <= 1'b0;
        t_reset();
        t_levels();
        t_bypass();
        t_gating();
        t_nesting();
        t_preempt();
        summarize();
    end
endmodule
